/* File: design/aics_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "aics_defs.vh"

module aics_top #(
    parameter NCH        = `AICS_NCH,
    parameter CYCLE_CLKS = `AICS_CYCLE_CLKS,
    parameter FIFO_DEPTH = `AICS_FIFO_DEPTH
) (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // parameter writes from the bus master
    input  wire        prm_wr,
    input  wire [4:0]  prm_addr,
    input  wire [7:0]  prm_data,
    // process image reads
    input  wire        pi_rd,
    input  wire [2:0]  pi_addr,
    output reg  [7:0]  pi_rdata_r,
    output reg         pi_rvalid_r,
    // converter samples
    input  wire        cnv_valid,
    output wire        cnv_ready,
    input  wire [1:0]  cnv_chan,
    input  wire [15:0] cnv_data,
    // conversion cycle control
    output reg         cnv_start_r,
    output reg  [3:0]  chan_en_r,
    output reg  [3:0]  cyc_miss_r,
    // channel status
    output reg  [3:0]  channel_fault_indicator,
    output reg  [3:0]  prm_err_r,
    output reg  [3:0]  over_r,
    output reg  [3:0]  under_r
);

    // ***********************************
    // helpers
    // ***********************************

    function known;
        input [7:0] c;
        begin
            case (c)
            `AICS_FN_N10V,
            `AICS_FN_N4V,
            `AICS_FN_N400MV,
            `AICS_FN_N20MA,
            `AICS_FN_N420MA,
            `AICS_FN_D10V,
            `AICS_FN_D4V,
            `AICS_FN_D400MV,
            `AICS_FN_D20MA,
            `AICS_FN_D420MA:
                known = 1'b1;
            default:
                known = 1'b0;
            endcase
        end
    endfunction

    // ***********************************
    // declarations
    // ***********************************

    reg  [7:0]  code_r [0:NCH-1];
    reg  [15:0] img_r  [0:NCH-1];
    reg  [3:0]  upd_r;
    reg  [3:0]  active;
    reg  [3:0]  bad;
    reg  [15:0] cyc_cnt_r;
    wire        cyc_end;
    wire [17:0] fifo_out;
    wire        fifo_vld;
    wire        drain_rdy;
    wire        take;
    wire [1:0]  s_chan;
    wire [15:0] s_raw;
    wire [15:0] s_value;
    wire        s_over;
    wire        s_under;
    wire        s_fault;
    wire        s_ok;
    wire [4:0]  fn_idx;
    wire        img_wr;
    integer     i;
    integer     ci;
    integer     ri;
    integer     fi;

    // ***********************************
    // channel state from stored codes
    // ***********************************

    always @* begin
        active = 4'h0;
        bad    = 4'h0;
        for (ci = 0; ci < NCH; ci = ci + 1) begin
            active[ci] = known(code_r[ci]);
            bad[ci]    = ~known(code_r[ci]) &
                         (code_r[ci] != `AICS_FN_OFF);
        end
    end

    // ***********************************
    // parameter bytes
    // ***********************************

    assign fn_idx = prm_addr - `AICS_PRM_FN0;

    // codes live here; a zero code leaves the stored value alone
    always @(posedge ref_clk) begin
        if (!rstn) begin
            for (i = 0; i < NCH; i = i + 1)
                code_r[i] <= `AICS_FN_DEFAULT;
        end else if (prm_wr && prm_addr >= `AICS_PRM_FN0 &&
                     prm_addr <= `AICS_PRM_FN3 &&
                     prm_data != `AICS_FN_KEEP) begin
            code_r[fn_idx[1:0]] <= prm_data;
        end
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            chan_en_r <= 4'h0;
            prm_err_r <= 4'h0;
        end else begin
            chan_en_r <= active;
            prm_err_r <= bad;
        end
    end

    // ***********************************
    // conversion cycle timer
    // ***********************************

    // 16-bit count: CYCLE_CLKS may not exceed 65536
    assign cyc_end = (cyc_cnt_r == CYCLE_CLKS - 1);

    always @(posedge ref_clk) begin
        if (!rstn) begin
            cyc_cnt_r   <= 16'h0000;
            cnv_start_r <= 1'b0;
        end else begin
            cnv_start_r <= cyc_end;
            if (cyc_end)
                cyc_cnt_r <= 16'h0000;
            else
                cyc_cnt_r <= cyc_cnt_r + 16'h0001;
        end
    end

    // ***********************************
    // sample buffer
    // ***********************************

    // drain pauses on a parameter write so a code never changes
    // under a sample being scaled; the fifo absorbs the gap
    assign drain_rdy = ~prm_wr;
    assign take      = fifo_vld & drain_rdy;
    assign s_chan    = fifo_out[17:16];
    assign s_raw     = fifo_out[15:0];
    // samples of idle or bad-code channels are dropped, not stored
    assign img_wr    = take & s_ok;

    aics_fifo #(
        .WIDTH (18),
        .DEPTH (FIFO_DEPTH),
        .AW    (2)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .in_vld    (cnv_valid),
        .in_rdy_r  (cnv_ready),
        .in_data   ({cnv_chan, cnv_data}),
        .out_vld_r (fifo_vld),
        .out_rdy   (drain_rdy),
        .out_data  (fifo_out)
    );

    // ***********************************
    // scaling
    // ***********************************

    aics_scale u_scale (
        .raw     (s_raw),
        .code    (code_r[s_chan]),
        .value   (s_value),
        .over    (s_over),
        .under   (s_under),
        .fault   (s_fault),
        .code_ok (s_ok)
    );

    // ***********************************
    // image words
    // ***********************************

    always @(posedge ref_clk) begin
        if (!rstn) begin
            for (ri = 0; ri < NCH; ri = ri + 1)
                img_r[ri] <= 16'h0000;
        end else begin
            // scaling covers codes 28h..2dh and 58h..5dh, less 2bh and 5bh
            if (img_wr)
                img_r[s_chan] <= s_value;
            // an idle channel shows nothing, not a stale reading
            for (ri = 0; ri < NCH; ri = ri + 1) begin
                if (!active[ri])
                    img_r[ri] <= 16'h0000;
            end
        end
    end

    // ***********************************
    // channel flags
    // ***********************************

    // per-sample levels: the next sample decides; an idle or bad-code channel clears them
    always @(posedge ref_clk) begin
        if (!rstn) begin
            channel_fault_indicator <= 4'h0;
            over_r  <= 4'h0;
            under_r <= 4'h0;
        end else begin
            if (img_wr) begin
                over_r[s_chan]  <= s_over;
                under_r[s_chan] <= s_under;
                channel_fault_indicator[s_chan] <= s_fault;
            end
            for (fi = 0; fi < NCH; fi = fi + 1) begin
                if (!active[fi]) begin
                    over_r[fi]  <= 1'b0;
                    under_r[fi] <= 1'b0;
                    channel_fault_indicator[fi] <= 1'b0;
                end
            end
        end
    end

    // ***********************************
    // refresh supervision
    // ***********************************

    // a sample landing on the closing edge counts for the next cycle
    always @(posedge ref_clk) begin
        if (!rstn) begin
            upd_r      <= 4'h0;
            cyc_miss_r <= 4'h0;
        end else if (cyc_end) begin
            cyc_miss_r <= active & ~upd_r;
            upd_r      <= 4'h0;
            if (take && s_ok)
                upd_r[s_chan] <= 1'b1;
        end else if (take && s_ok) begin
            upd_r[s_chan] <= 1'b1;
        end
    end

    // ***********************************
    // process image read port
    // ***********************************

    // even address is the high byte carrying the sign bit
    always @(posedge ref_clk) begin
        if (!rstn) begin
            pi_rdata_r  <= 8'h00;
            pi_rvalid_r <= 1'b0;
        end else begin
            pi_rvalid_r <= pi_rd;
            if (pi_rd) begin
                if (pi_addr[0])
                    pi_rdata_r <= img_r[pi_addr[2:1]][7:0];
                else
                    pi_rdata_r <= img_r[pi_addr[2:1]][15:8];
            end
        end
    end

endmodule

`default_nettype wire

/* File: design/aics_defs.vh */
`ifndef AICS_DEFS_VH
`define AICS_DEFS_VH

// ***********************************
// channels and process image
// ***********************************
`define AICS_NCH        4
`define AICS_CHW        2
`define AICS_PI_BYTES   8
`define AICS_PI_AW      3
`define AICS_PRM_AW     5
`define AICS_PRM_FN0    5'h02
`define AICS_PRM_FN3    5'h05
`define AICS_RAW_W      16

// ***********************************
// function codes
// ***********************************
`define AICS_FN_KEEP    8'h00
`define AICS_FN_OFF     8'hff
`define AICS_FN_DEFAULT 8'h28
`define AICS_FN_N10V    8'h28
`define AICS_FN_N4V     8'h29
`define AICS_FN_N400MV  8'h2a
`define AICS_FN_N20MA   8'h2c
`define AICS_FN_N420MA  8'h2d
`define AICS_FN_D10V    8'h58
`define AICS_FN_D4V     8'h59
`define AICS_FN_D400MV  8'h5a
`define AICS_FN_D20MA   8'h5c
`define AICS_FN_D420MA  8'h5d

// ***********************************
// raw scale: 16384 counts = rated full scale
// ***********************************
`define AICS_RAW_SHIFT  14
`define AICS_RAW_4MA    16'h0ccd
`define AICS_RAW_20MA   16'h4000

// ***********************************
// gains, offsets, limits
// ***********************************
`define AICS_G_NAT      17'h06c00
`define AICS_G_NAT420   17'h08700
`define AICS_G_D10      17'h02710
`define AICS_G_D4       17'h00fa0
`define AICS_G_D20      17'h04e20
`define AICS_OFS_ZERO   16'h0000
`define AICS_OFS_NAT420 16'he500
`define AICS_OFS_D420   16'hf060
`define AICS_P27648     16'h6c00
`define AICS_M27648     16'h9400
`define AICS_P32511     16'h7eff
`define AICS_M32512     16'h8100
`define AICS_M4864      16'hed00
`define AICS_P10000     16'h2710
`define AICS_M10000     16'hd8f0
`define AICS_P4950      16'h1356
`define AICS_M4950      16'hecaa
`define AICS_P25000     16'h61a8
`define AICS_M25000     16'h9e58
`define AICS_P20000     16'h4e20
`define AICS_M3200      16'hf380

// ***********************************
// timing
// ***********************************
`define AICS_CLK_MHZ    20
`define AICS_CYCLE_NS   800000
`define AICS_CYCLE_CLKS (`AICS_CYCLE_NS * `AICS_CLK_MHZ / 1000)
`define AICS_FIFO_DEPTH 4

`endif

/* File: design/aics_fifo.v */
`timescale 1ns/1ps
`default_nettype none

module aics_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             ref_clk,
    input  wire             rstn,
    // fill side
    input  wire             in_vld,
    output reg              in_rdy_r,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output reg              out_vld_r,
    input  wire             out_rdy,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_r;
    reg [AW-1:0]    rp_r;
    reg [AW:0]      cnt_r;
    reg [AW:0]      cnt_nxt;
    wire            push;
    wire            pop;

    assign push     = in_vld & in_rdy_r;
    assign pop      = out_vld_r & out_rdy;
    assign out_data = mem[rp_r];

    always @* begin
        cnt_nxt = cnt_r;
        if (push & ~pop)
            cnt_nxt = cnt_r + 1'b1;
        else if (pop & ~push)
            cnt_nxt = cnt_r - 1'b1;
    end

    // flags are registered so the ready seen outside is a flop
    always @(posedge ref_clk) begin
        if (!rstn) begin
            wp_r      <= {AW{1'b0}};
            rp_r      <= {AW{1'b0}};
            cnt_r     <= {(AW+1){1'b0}};
            in_rdy_r  <= 1'b0;
            out_vld_r <= 1'b0;
        end else begin
            if (push) begin
                mem[wp_r] <= in_data;
                wp_r      <= (wp_r == DEPTH - 1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (pop)
                rp_r <= (rp_r == DEPTH - 1) ? {AW{1'b0}} : rp_r + 1'b1;
            cnt_r     <= cnt_nxt;
            in_rdy_r  <= (cnt_nxt != DEPTH);
            out_vld_r <= (cnt_nxt != {(AW+1){1'b0}});
        end
    end

endmodule

`default_nettype wire

/* File: design/aics_scale.v */
`timescale 1ns/1ps
`default_nettype none
`include "aics_defs.vh"

module aics_scale (
    // sample in
    input  wire [15:0] raw,
    input  wire [7:0]  code,
    // result out
    output reg  [15:0] value,
    output reg         over,
    output reg         under,
    output reg         fault,
    output reg         code_ok
);

    // {ok, current, gain, offset, hi, lo}
    function [66:0] dec;
        input [7:0] c;
        begin
            case (c)
            `AICS_FN_N10V:   dec = {2'b10, `AICS_G_NAT, `AICS_OFS_ZERO,
                                    `AICS_P27648, `AICS_M27648};
            `AICS_FN_N4V,
            `AICS_FN_N400MV: dec = {2'b10, `AICS_G_NAT, `AICS_OFS_ZERO,
                                    `AICS_P32511, `AICS_M32512};
            `AICS_FN_N20MA:  dec = {2'b11, `AICS_G_NAT, `AICS_OFS_ZERO,
                                    `AICS_P32511, `AICS_M32512};
            `AICS_FN_N420MA: dec = {2'b11, `AICS_G_NAT420, `AICS_OFS_NAT420,
                                    `AICS_P32511, `AICS_M4864};
            `AICS_FN_D10V:   dec = {2'b10, `AICS_G_D10, `AICS_OFS_ZERO,
                                    `AICS_P10000, `AICS_M10000};
            `AICS_FN_D4V,
            `AICS_FN_D400MV: dec = {2'b10, `AICS_G_D4, `AICS_OFS_ZERO,
                                    `AICS_P4950, `AICS_M4950};
            `AICS_FN_D20MA:  dec = {2'b11, `AICS_G_D20, `AICS_OFS_ZERO,
                                    `AICS_P25000, `AICS_M25000};
            `AICS_FN_D420MA: dec = {2'b11, `AICS_G_D20, `AICS_OFS_D420,
                                    `AICS_P20000, `AICS_M3200};
            default:         dec = 67'h0;
            endcase
        end
    endfunction

    reg [66:0]        d;
    reg signed [33:0] prod;
    reg signed [19:0] sc;
    reg signed [19:0] hi;
    reg signed [19:0] lo;

    // 20-bit intermediate keeps headroom so saturation sees true sign
    always @* begin
        d       = dec(code);
        code_ok = d[66];
        prod    = $signed(raw) * $signed({1'b0, d[64:48]});
        sc      = prod[33:`AICS_RAW_SHIFT] +
                  {{4{d[47]}}, d[47:32]};
        hi      = {{4{d[31]}}, d[31:16]};
        lo      = {{4{d[15]}}, d[15:0]};
        over    = 1'b0;
        under   = 1'b0;
        if (sc > hi) begin
            value = d[31:16];
            over  = 1'b1;
        end else if (sc < lo) begin
            value = d[15:0];
            under = 1'b1;
        end else begin
            value = sc[15:0];
        end
        fault = d[65] & (($signed(raw) < $signed(`AICS_RAW_4MA)) |
                         ($signed(raw) > $signed(`AICS_RAW_20MA)));
    end

endmodule

`default_nettype wire

/* File: dv/aics_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module aics_top_monitor #(
    parameter CYCLE_CLKS = 16000
) (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rstn,
    // bus side
    input wire logic       prm_wr,
    input wire logic [4:0] prm_addr,
    input wire logic [7:0] prm_data,
    input wire logic       pi_rd,
    input wire logic       pi_rvalid_r,
    // converter side
    input wire logic       cnv_valid,
    input wire logic       cnv_ready,
    input wire logic       cnv_start_r,
    // status
    input wire logic [3:0] chan_en_r,
    input wire logic [3:0] prm_err_r,
    input wire logic [3:0] over_r,
    input wire logic [3:0] under_r
);
    // ****
    // cycle counter
    // ****
    logic [31:0] cnt_r;
    logic        seen_r;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cnt_r  <= 32'h0;
            seen_r <= 1'b0;
        end else begin
            cnt_r  <= cnv_start_r ? 32'h0 : cnt_r + 32'h1;
            seen_r <= seen_r | cnv_start_r;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // ****
    // checks
    // ****
    rd_answer_a: assert property (pi_rd |=> pi_rvalid_r)
        else $error("read not answered");
    rd_single_a: assert property (!pi_rd |=> !pi_rvalid_r)
        else $error("read answer without read");
    dflt_code_a: assert property ($rose(rstn) |=> chan_en_r == 4'hf)
        else $error("channels not active after reset");
    keep_code_a: assert property (
        (!(prm_wr && prm_data != 8'h00))[*3]
        |=> $stable(chan_en_r) && $stable(prm_err_r))
        else $error("channel setup changed without a code");
    off_code_a: assert property (
        prm_wr && prm_addr == 5'h02 && prm_data == 8'hff
        ##1 !(prm_wr && prm_addr == 5'h02) |=> !chan_en_r[0])
        else $error("channel 0 not switched off");
    bad_code_a: assert property (
        prm_wr && prm_addr == 5'h03 && prm_data == 8'h30
        ##1 !(prm_wr && prm_addr == 5'h03) |=> prm_err_r[1] && !chan_en_r[1])
        else $error("unlisted code not flagged");
    flag_excl_a: assert property ((over_r & under_r) == 4'h0)
        else $error("over and under together");
    en_err_a: assert property ((chan_en_r & prm_err_r) == 4'h0)
        else $error("bad code channel active");
    ready_fall_a: assert property ($fell(cnv_ready) |-> $past(cnv_valid))
        else $error("ready fell without a sample");
    start_pulse_a: assert property (cnv_start_r |=> !cnv_start_r)
        else $error("cycle start wider than one clock");
    start_period_a: assert property (
        cnv_start_r && seen_r |-> cnt_r == CYCLE_CLKS - 1)
        else $error("cycle period wrong");
    start_bound_a: assert property (cnt_r < CYCLE_CLKS + 3)
        else $error("cycle start overdue");

    cover property (cnv_valid && cnv_ready);
    cover property (prm_wr && prm_data == 8'hff);
    cover property ($fell(cnv_ready));
endmodule

`default_nettype wire

/* File: dv/aics_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module aics_cpu_model (
    // clock
    input  wire logic       ref_clk,
    // parameter writes
    output var  logic       prm_wr,
    output var  logic [4:0] prm_addr,
    output var  logic [7:0] prm_data,
    // image reads
    output var  logic       pi_rd,
    output var  logic [2:0] pi_addr,
    input  wire logic [7:0] pi_rdata_r,
    input  wire logic       pi_rvalid_r
);
    // ****
    // bus tasks
    // ****
    initial begin
        prm_wr = 1'b0;
        prm_addr = 5'h00;
        prm_data = 8'h00;
        pi_rd = 1'b0;
        pi_addr = 3'h0;
    end

    // one code byte per channel, bytes 2..5
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        prm_wr = 1'b1;
        prm_addr = a;
        prm_data = d;
        @(posedge ref_clk);
        #1;
        prm_wr = 1'b0;
        prm_data = ~d;
    endtask

    task automatic rdb(input logic [2:0] a, output logic [7:0] b);
        @(posedge ref_clk);
        #1;
        pi_rd = 1'b1;
        pi_addr = a;
        @(posedge ref_clk);
        #1;
        pi_rd = 1'b0;
        pi_addr = ~a;
        b = pi_rvalid_r ? pi_rdata_r : 8'hxx;
    endtask

    // idle write to an unused byte stalls the drain
    task automatic hold(input int n);
        @(posedge ref_clk);
        #1;
        prm_wr = 1'b1;
        prm_addr = 5'h00;
        prm_data = 8'h00;
        repeat (n) @(posedge ref_clk);
        #1;
        prm_wr = 1'b0;
    endtask
endmodule

`default_nettype wire

/* File: dv/test_analog_input_code_scaler.sv */
`timescale 1ns/1ps
`default_nettype none

module test_analog_input_code_scaler;
    localparam CYC = 40;
    logic        ref_clk, rstn, cnv_valid;
    logic [1:0]  cnv_chan;
    logic [15:0] cnv_data;
    wire         prm_wr, pi_rd, pi_rvalid_r, cnv_ready, cnv_start_r;
    wire  [4:0]  prm_addr;
    wire  [7:0]  prm_data, pi_rdata_r;
    wire  [2:0]  pi_addr;
    wire  [3:0]  chan_en_r, cyc_miss_r, channel_fault_indicator;
    wire  [3:0]  prm_err_r, over_r, under_r;
    int          mismatches, checks_done, n;
    int          cidx [4] = '{0, 0, 0, 0};
    logic [7:0]  codes [10] = '{8'h28, 8'h29, 8'h2a, 8'h2c, 8'h2d,
                                8'h58, 8'h59, 8'h5a, 8'h5c, 8'h5d};
    int gn [10] = '{27648, 27648, 27648, 27648, 34560,
                    10000, 4000, 4000, 20000, 20000};
    int of [10] = '{0, 0, 0, 0, -6912, 0, 0, 0, 0, -4000};
    int hi [10] = '{27648, 32511, 32511, 32511, 32511,
                    10000, 4950, 4950, 25000, 20000};
    int lo [10] = '{-27648, -32512, -32512, -32512, -4864,
                    -10000, -4950, -4950, -25000, -3200};
    logic [15:0] corner [6] = '{16'h4000, 16'hc000, 16'h7fff,
                                16'h8000, 16'h0000, 16'h0ccc};

    aics_top #(.CYCLE_CLKS(CYC)) DUT (
        .ref_clk, .rstn, .prm_wr, .prm_addr, .prm_data, .pi_rd, .pi_addr,
        .pi_rdata_r, .pi_rvalid_r, .cnv_valid, .cnv_ready, .cnv_chan,
        .cnv_data, .cnv_start_r, .chan_en_r, .cyc_miss_r,
        .channel_fault_indicator, .prm_err_r, .over_r, .under_r);

    aics_cpu_model u_cpu (.ref_clk, .prm_wr, .prm_addr, .prm_data, .pi_rd,
        .pi_addr, .pi_rdata_r, .pi_rvalid_r);

    // ****
    // helpers
    // ****
    function automatic logic [18:0] expv(int k, logic [15:0] r);
        int   v;
        logic f;
        v = (($signed(r) * gn[k]) >>> 14) + of[k];
        f = (k == 3 || k == 4 || k > 7) && ($signed(r) < 3277
            || $signed(r) > 16384);
        return {f, v < lo[k], v > hi[k], v > hi[k] ? hi[k][15:0]
            : v < lo[k] ? lo[k][15:0] : v[15:0]};
    endfunction

    task automatic tally_and_finish;
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic tmo;
        mismatches++;
        tally_and_finish();
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask

    task automatic send(input logic [1:0] ch, input logic [15:0] r);
        int w;
        w = 0;
        cnv_valid = 1'b1;
        cnv_chan = ch;
        cnv_data = r;
        while (!cnv_ready && w < 50) begin
            tick(1);
            w++;
        end
        if (w >= 50) tmo();
        tick(1);
        cnv_valid = 1'b0;
        cnv_data = ~r;
        tick(5);
    endtask

    // inactive channel reads zero with flags clear
    task automatic chkch(input int ch, input logic [15:0] r);
        logic [7:0]  hb, lb;
        logic [18:0] e;
        e = cidx[ch] < 0 ? 19'h0 : expv(cidx[ch], r);
        u_cpu.rdb(3'(2 * ch), hb);
        u_cpu.rdb(3'(2 * ch + 1), lb);
        chk({hb, lb}, e[15:0]);
        chk({13'h0, channel_fault_indicator[ch], under_r[ch], over_r[ch]},
            {13'h0, e[18:16]});
    endtask

    task automatic wait_start;
        int w;
        w = 0;
        while (!cnv_start_r && w < 100) begin
            tick(1);
            w++;
        end
        if (w >= 100) tmo();
        tick(1);
    endtask

    // ****
    // stimulus
    // ****
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        #5_000_000;
        tmo();
    end

    initial begin
        logic [15:0] r;
        rstn = 1'b0;
        cnv_valid = 1'b0;
        cnv_chan = 2'h0;
        cnv_data = 16'h0000;
        mismatches = 0;
        checks_done = 0;
        r = 16'($urandom(32'h5dfc5728));
        tick(5);
        rstn = 1'b1;
        tick(1);
        chk({8'h0, chan_en_r, prm_err_r}, 16'h00f0);
        for (int k = 0; k < 10; k++) begin
            u_cpu.wr(5'(2 + k % 4), codes[k]);
            cidx[k % 4] = k;
            tick(1);
            chk({8'h0, chan_en_r, prm_err_r}, 16'h00f0);
            for (int j = 0; j < 9; j++) begin
                r = j < 6 ? corner[j] : 16'($urandom);
                send(2'(k % 4), r);
                chkch(k % 4, r);
            end
        end
        u_cpu.wr(5'h03, 8'h00);
        send(2'd1, 16'h4000);
        chkch(1, 16'h4000);
        u_cpu.wr(5'h02, 8'hff);
        cidx[0] = -1;
        tick(1);
        chk({12'h0, chan_en_r}, 16'h000e);
        send(2'd0, 16'h2000);
        chkch(0, 16'h2000);
        u_cpu.wr(5'h03, 8'h30);
        tick(1);
        chk({8'h0, chan_en_r, prm_err_r}, 16'h00c2);
        u_cpu.wr(5'h02, 8'h28);
        cidx[0] = 0;
        r = 16'($urandom);
        n = 0;
        fork
            u_cpu.hold(12);
            begin
                cnv_valid = 1'b1;
                cnv_chan = 2'd2;
                cnv_data = r;
                repeat (10) begin
                    n += int'(cnv_ready);
                    tick(1);
                end
                cnv_valid = 1'b0;
            end
        join
        chk(16'(n), 16'h0004);
        chk({15'h0, cnv_ready}, 16'h0000);
        tick(8);
        chk({15'h0, cnv_ready}, 16'h0001);
        chkch(2, r);
        wait_start();
        wait_start();
        tick(2);
        chk({12'h0, cyc_miss_r}, 16'h000d);
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        tick(1);
        chk({8'h0, chan_en_r, prm_err_r}, 16'h00f0);
        tally_and_finish();
    end
endmodule

bind aics_top aics_top_monitor #(.CYCLE_CLKS(CYCLE_CLKS)) u_mon (
    .ref_clk, .rstn, .prm_wr, .prm_addr, .prm_data, .pi_rd, .pi_rvalid_r,
    .cnv_valid, .cnv_ready, .cnv_start_r, .chan_en_r, .prm_err_r,
    .over_r, .under_r);

`default_nettype wire
